//--- design/smpc_pkg.sv
// constants for the smbus master poll configuration and status block
// assumes an 8-bit register port from the serial slave and one clock
package smpc_pkg;

  localparam int SMPC_NUM_DEV = 8;

  // register addresses
  localparam logic [7:0] SMPC_A_RESTART = 8'hb0;
  localparam logic [7:0] SMPC_A_CKSUM_EN = 8'hb1;
  localparam logic [7:0] SMPC_A_FMT_LOW = 8'hb2;
  localparam logic [7:0] SMPC_A_FMT_HIGH = 8'hb3;
  localparam logic [7:0] SMPC_A_MASTER = 8'hb5;
  localparam logic [7:0] SMPC_A_NO_ACK = 8'hb6;
  localparam logic [7:0] SMPC_A_CKSUM_ERR = 8'hb7;
  localparam logic [7:0] SMPC_A_TIMEOUT = 8'hb8;
  localparam logic [7:0] SMPC_A_LIMIT = 8'hb9;
  localparam logic [7:0] SMPC_A_INVALID = 8'hba;
  localparam logic [7:0] SMPC_A_NACK_MASK = 8'hbc;

  // reset values
  localparam logic [7:0] SMPC_RST_RESTART = 8'hff;
  localparam logic [7:0] SMPC_RST_CKSUM_EN = 8'h00;
  localparam logic [7:0] SMPC_RST_FMT_LOW = 8'h03;
  localparam logic [7:0] SMPC_RST_FMT_HIGH = 8'h00;
  localparam logic [7:0] SMPC_RST_MASTER = 8'h08;
  localparam logic [7:0] SMPC_RST_FLAGS = 8'h00;
  localparam logic [7:0] SMPC_RST_NACK_MASK = 8'h00;
  localparam logic [7:0] SMPC_RST_TEMP = 8'h80;

  // master_control fields
  localparam int SMPC_B_ENABLE = 0;
  localparam int SMPC_B_HYS_LO = 1;
  localparam int SMPC_HYS_W = 4;
  localparam int SMPC_B_REM1 = 5;
  localparam int SMPC_B_REM2 = 6;
  localparam int SMPC_B_HUB = 7;

  // invalid-code flags exist for devices 0..4 only
  localparam logic [7:0] SMPC_INVALID_MASK = 8'h1f;
  localparam logic [2:0] SMPC_LAST_HUB_DEV = 3'd4;
  localparam logic [2:0] SMPC_LAST_BLOCK_DEV = 3'd3;
  localparam logic [2:0] SMPC_FIRST_MODULE = 3'd1;
  localparam logic [2:0] SMPC_LAST_REM1 = 3'd2;
  localparam logic [2:0] SMPC_RESERVED_DEV = 3'd4;
  localparam logic [2:0] SMPC_HUB_DEV = 3'd0;

  // temperature format codes
  typedef enum logic [1:0] {
    SMPC_FMT_TWOS = 2'b00,
    SMPC_FMT_SPD = 2'b01,
    SMPC_FMT_UNSIGNED = 2'b10,
    SMPC_FMT_SPECIAL = 2'b11
  } smpc_fmt_e;

  // spd word layout
  localparam int SMPC_SPD_SIGN = 12;
  localparam int SMPC_SPD_INT_LO = 4;

endpackage : smpc_pkg

//--- design/smpc_fmt.sv
// temperature format converter for one returned reading
// assumes raw holds the returned word, low byte for byte reads
`timescale 1ns/1ps
`default_nettype none
module smpc_fmt (
  input wire logic [2:0] dev,
  input wire smpc_pkg::smpc_fmt_e fmt,
  input wire logic [15:0] raw,
  output logic [8:0] value,
  output logic [7:0] stored,
  output logic ok
);
  import smpc_pkg::*;

  logic [8:0] spd_int;

  always_comb begin
    spd_int = {raw[SMPC_SPD_SIGN], raw[SMPC_SPD_INT_LO +: 8]};
    value = {raw[7], raw[7:0]};
    stored = raw[7:0];
    ok = 1'b1;
    case (fmt)
      SMPC_FMT_TWOS: begin
        value = {raw[7], raw[7:0]};
      end
      SMPC_FMT_SPD: begin
        // clamp to the signed byte range that storage can hold
        value = spd_int;
        if (!spd_int[8] && spd_int[7]) begin
          stored = 8'h7f;
        end else if (spd_int[8] && !spd_int[7]) begin
          stored = 8'h80;
        end else begin
          stored = spd_int[7:0];
        end
      end
      SMPC_FMT_UNSIGNED: begin
        value = {1'b0, raw[7:0]};
      end
      SMPC_FMT_SPECIAL: begin
        if (dev <= SMPC_LAST_BLOCK_DEV) begin
          value = {raw[7], raw[7:0]};
        end else if (dev == SMPC_RESERVED_DEV) begin
          ok = 1'b0;
        end else begin
          value = {1'b0, raw[7:0]};
        end
      end
      default: begin
        ok = 1'b0;
      end
    endcase
  end

endmodule : smpc_fmt
`default_nettype wire

//--- design/smpc_top.sv
// smbus master poll sequencer with its configuration and status registers
// assumes a transaction engine on the same clock doing the bus cycles,
// and limits, remote readings and register strobes from same-clock logic
//
// Behaviour
// - one checksum enable per slave; set means append and check checksum byte.
// - two-bit format: 00 twos complement, 01 spd, 10 unsigned.
// - slaves 0-3 code 11 selects block reads; slave 0 field bits 1:0.
// - slave 4 code 11 is reserved and yields no reading.
// - slaves 5-7 code 11 stores the returned byte unconverted.
// - master enable bit gates all polling.
// - one four-bit hysteresis applies to every slave's limit check.
// - remote one reading overwrites modules 0 and 1 temperatures.
// - remote two reading overwrites modules 2 and 3 temperatures.
// - hub mode takes module temperatures from hub, overriding remote options.
// - per-slave no-acknowledge flag set when the slave does not ack.
// - per-slave flag set on checksum byte mismatch.
// - per-slave flag set on transaction timeout.
// - per-slave flag set when a reading lies outside limits, cleared once one lies inside the hysteresis band.
// - invalid hub code flags in bits 0-4; bits 5-7 read zero.
// - format_select_low resets to 0x03.
// - master_control resets to 0x08.
// - masked slaves' no-acknowledge flags do not raise the alert.
// - repeated start per slave when enabled; enables reset to all ones.
`timescale 1ns/1ps
`default_nettype none
module smpc_top #(
  parameter int NUM_DEV = 8,
  parameter logic [7:0] RESERVED_CODE = 8'hff
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic txn_start,
  output logic [2:0] txn_dev,
  output logic txn_cksum,
  output logic txn_block,
  output logic txn_restart,
  input wire logic txn_byte_vld,
  input wire logic [2:0] txn_byte_idx,
  input wire logic [15:0] txn_data,
  input wire logic txn_done,
  input wire logic txn_nack,
  input wire logic txn_cksum_err,
  input wire logic txn_timeout,
  input wire logic [7:0] high_limit,
  input wire logic [7:0] low_limit,
  input wire logic [7:0] remote_one_temp,
  input wire logic [7:0] remote_two_temp,
  output logic [8*NUM_DEV-1:0] temp_vals,
  output logic poll_alert
);
  import smpc_pkg::*;

  if (NUM_DEV != SMPC_NUM_DEV) begin : g_check
    $error("smpc_top serves exactly eight polled slaves");
  end

  typedef enum logic [2:0] {
    SMPC_ST_IDLE = 3'b001,
    SMPC_ST_REQ = 3'b010,
    SMPC_ST_WAIT = 3'b100
  } smpc_state_e;

  smpc_state_e state_q;
  logic [2:0] dev_q;
  logic [7:0] restart_en_q;
  logic [7:0] cksum_en_q;
  logic [7:0] fmt_low_q;
  logic [7:0] fmt_high_q;
  logic [7:0] master_q;
  logic [7:0] nack_mask_q;
  logic [7:0] no_ack_q;
  logic [7:0] cksum_err_q;
  logic [7:0] timeout_q;
  logic [7:0] limit_q;
  logic [7:0] invalid_q;
  logic [7:0] temp_q [NUM_DEV];
  logic [7:0] rdata_d;

  logic master_on;
  logic hub_mode;
  logic rem1_on;
  logic rem2_on;
  logic [3:0] hys;
  logic [2:0] target;
  logic hub_byte;
  logic byte_take;
  logic [8:0] conv_value;
  logic [7:0] conv_stored;
  logic conv_ok;
  smpc_fmt_e target_fmt;

  function automatic smpc_fmt_e fmt_of(input logic [2:0] d,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [1:0] f;
    f = d[2] ? hi[{d[1:0], 1'b0} +: 2] : lo[{d[1:0], 1'b0} +: 2];
    return smpc_fmt_e'(f);
  endfunction : fmt_of

  function automatic logic [9:0] sext10(input logic [8:0] v);
    return {v[8], v};
  endfunction : sext10

  // modules whose reading comes from somewhere else are not polled
  function automatic logic skip_dev(input logic [2:0] d,
                                    input logic hub,
                                    input logic r1,
                                    input logic r2,
                                    input smpc_fmt_e f);
    logic module_dev;
    module_dev = (d >= SMPC_FIRST_MODULE) && (d <= SMPC_LAST_HUB_DEV);
    if (module_dev && hub) begin
      return 1'b1;
    end
    if (module_dev && (d <= SMPC_LAST_REM1) && r1) begin
      return 1'b1;
    end
    if (module_dev && (d > SMPC_LAST_REM1) && r2) begin
      return 1'b1;
    end
    return (d == SMPC_RESERVED_DEV) && (f == SMPC_FMT_SPECIAL);
  endfunction : skip_dev

  assign master_on = master_q[SMPC_B_ENABLE];
  assign hys = master_q[SMPC_B_HYS_LO +: SMPC_HYS_W];
  assign hub_mode = master_q[SMPC_B_HUB];
  assign rem1_on = master_q[SMPC_B_REM1] && !hub_mode;
  assign rem2_on = master_q[SMPC_B_REM2] && !hub_mode;

  // hub block bytes 1..4 carry the module temperatures
  assign hub_byte = hub_mode && (dev_q == SMPC_HUB_DEV);
  always_comb begin
    target = dev_q;
    byte_take = 1'b0;
    if (txn_byte_vld && state_q == SMPC_ST_WAIT) begin
      if (hub_byte && txn_byte_idx <= SMPC_LAST_HUB_DEV) begin
        target = txn_byte_idx;
        byte_take = 1'b1;
      end else if (txn_byte_idx == 3'd0) begin
        byte_take = 1'b1;
      end
    end
  end

  assign target_fmt = fmt_of(target, fmt_low_q, fmt_high_q);

  smpc_fmt i_smpc_fmt (
    .dev(target),
    .fmt(target_fmt),
    .raw(txn_data),
    .value(conv_value),
    .stored(conv_stored),
    .ok(conv_ok)
  );

  // configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      restart_en_q <= SMPC_RST_RESTART;
      cksum_en_q <= SMPC_RST_CKSUM_EN;
      fmt_low_q <= SMPC_RST_FMT_LOW;
      fmt_high_q <= SMPC_RST_FMT_HIGH;
      master_q <= SMPC_RST_MASTER;
      nack_mask_q <= SMPC_RST_NACK_MASK;
    end else if (reg_wr_en) begin
      // status addresses fall through: host writes have no effect
      case (reg_addr)
        SMPC_A_RESTART: restart_en_q <= reg_wdata;
        SMPC_A_CKSUM_EN: cksum_en_q <= reg_wdata;
        SMPC_A_FMT_LOW: fmt_low_q <= reg_wdata;
        SMPC_A_FMT_HIGH: fmt_high_q <= reg_wdata;
        SMPC_A_MASTER: master_q <= reg_wdata;
        SMPC_A_NACK_MASK: nack_mask_q <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // poll sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= SMPC_ST_IDLE;
      dev_q <= 3'd0;
      txn_dev <= 3'd0;
      txn_cksum <= 1'b0;
      txn_block <= 1'b0;
      txn_restart <= 1'b0;
    end else begin
      case (state_q)
        SMPC_ST_IDLE: begin
          // a transaction in flight always finishes before disabling
          if (master_on) begin
            if (skip_dev(dev_q, hub_mode, rem1_on, rem2_on,
                         fmt_of(dev_q, fmt_low_q, fmt_high_q))) begin
              dev_q <= dev_q + 3'd1;
            end else begin
              txn_dev <= dev_q;
              txn_cksum <= cksum_en_q[dev_q];
              txn_restart <= restart_en_q[dev_q];
              txn_block <= hub_byte ||
                ((dev_q <= SMPC_LAST_BLOCK_DEV) &&
                 (fmt_of(dev_q, fmt_low_q, fmt_high_q) ==
                  SMPC_FMT_SPECIAL));
              state_q <= SMPC_ST_REQ;
            end
          end
        end
        SMPC_ST_REQ: begin
          state_q <= SMPC_ST_WAIT;
        end
        SMPC_ST_WAIT: begin
          if (txn_done) begin
            dev_q <= dev_q + 3'd1;
            state_q <= SMPC_ST_IDLE;
          end
        end
        default: begin
          state_q <= SMPC_ST_IDLE;
        end
      endcase
    end
  end

  assign txn_start = (state_q == SMPC_ST_REQ);

  // bus error flags, refreshed when each poll completes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      no_ack_q <= SMPC_RST_FLAGS;
      cksum_err_q <= SMPC_RST_FLAGS;
      timeout_q <= SMPC_RST_FLAGS;
    end else if (txn_done && state_q == SMPC_ST_WAIT) begin
      no_ack_q[dev_q] <= txn_nack;
      cksum_err_q[dev_q] <= txn_cksum_err && cksum_en_q[dev_q];
      timeout_q[dev_q] <= txn_timeout;
    end
  end

  // limit check with hysteresis band
  logic [9:0] v10;
  logic [9:0] hi10;
  logic [9:0] lo10;
  logic [9:0] hys10;
  logic outside;
  logic inside_band;
  always_comb begin
    v10 = sext10(conv_value);
    hi10 = {2'b00, high_limit};
    lo10 = sext10({low_limit[7], low_limit});
    hys10 = {6'd0, hys};
    outside = ($signed(v10) > $signed(hi10)) ||
              ($signed(v10) < $signed(lo10));
    inside_band = ($signed(v10) <= $signed(hi10 - hys10)) &&
                  ($signed(v10) >= $signed(lo10 + hys10));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      limit_q <= SMPC_RST_FLAGS;
    end else if (byte_take && conv_ok && !txn_nack && !txn_timeout) begin
      if (outside) begin
        limit_q[target] <= 1'b1;
      end else if (inside_band) begin
        limit_q[target] <= 1'b0;
      end
    end
  end

  // reserved codes only come from the hub
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      invalid_q <= SMPC_RST_FLAGS;
    end else if (byte_take && target <= SMPC_LAST_HUB_DEV &&
                 (dev_q == SMPC_HUB_DEV)) begin
      invalid_q[target] <= (txn_data[7:0] == RESERVED_CODE);
    end
  end

  // stored temperatures; substitution wins over any polled byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_DEV; i++) begin
        temp_q[i] <= SMPC_RST_TEMP;
      end
    end else begin
      for (int i = 0; i < NUM_DEV; i++) begin
        if (rem1_on && i >= SMPC_FIRST_MODULE && i <= SMPC_LAST_REM1) begin
          temp_q[i] <= remote_one_temp;
        end else if (rem2_on && i > SMPC_LAST_REM1 &&
                     i <= SMPC_LAST_HUB_DEV) begin
          temp_q[i] <= remote_two_temp;
        end else if (byte_take && conv_ok && !txn_nack &&
                     !txn_timeout && target == i[2:0]) begin
          temp_q[i] <= conv_stored;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_DEV; i++) begin
      temp_vals[8*i +: 8] = temp_q[i];
    end
  end

  // alert from unmasked no-acknowledge flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      poll_alert <= 1'b0;
    end else begin
      poll_alert <= |(no_ack_q & ~nack_mask_q);
    end
  end

  // register read, one cycle latency; unmapped reads give zero
  always_comb begin
    case (reg_addr)
      SMPC_A_RESTART: rdata_d = restart_en_q;
      SMPC_A_CKSUM_EN: rdata_d = cksum_en_q;
      SMPC_A_FMT_LOW: rdata_d = fmt_low_q;
      SMPC_A_FMT_HIGH: rdata_d = fmt_high_q;
      SMPC_A_MASTER: rdata_d = master_q;
      SMPC_A_NO_ACK: rdata_d = no_ack_q;
      SMPC_A_CKSUM_ERR: rdata_d = cksum_err_q;
      SMPC_A_TIMEOUT: rdata_d = timeout_q;
      SMPC_A_LIMIT: rdata_d = limit_q;
      SMPC_A_INVALID: rdata_d = invalid_q & SMPC_INVALID_MASK;
      SMPC_A_NACK_MASK: rdata_d = nack_mask_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata <= rdata_d;
    end
  end

endmodule : smpc_top
`default_nettype wire

//--- dv/smpc_engine_model.sv
// behavioural transaction engine answering poll requests
// assumes one request outstanding; results change 1 ns after edges
`timescale 1ns/1ps
`default_nettype none
module smpc_engine_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic txn_start,
  input wire logic [2:0] txn_dev,
  input wire logic txn_block,
  input wire logic [15:0] rsp_data,
  input wire logic [2:0] rsp_err,
  input wire logic slow,
  output logic txn_byte_vld,
  output logic [2:0] txn_byte_idx,
  output logic [15:0] txn_data,
  output logic txn_done,
  output logic txn_nack,
  output logic txn_cksum_err,
  output logic txn_timeout
);
  int nb;
  // one process owns every output
  initial begin
    txn_byte_vld = 1'b0;
    txn_byte_idx = 3'h0;
    txn_data = 16'h0000;
    txn_done = 1'b0;
    txn_nack = 1'b0;
    txn_cksum_err = 1'b0;
    txn_timeout = 1'b0;
    forever begin
      @(posedge clk);
      if (rst_n && txn_start) begin
        // hub block reads return five bytes, one per cycle
        nb = (txn_block && txn_dev == 3'h0) ? 5 : 1;
        repeat (slow ? 6 : 1) @(posedge clk);
        for (int k = 0; k < nb; k++) begin
          #1 txn_byte_vld = 1'b1;
          txn_byte_idx = 3'(k);
          txn_data = rsp_data + 16'(k);
          txn_nack = rsp_err[2];
          txn_timeout = rsp_err[0];
          @(posedge clk);
        end
        // released data flips so a stale word never looks valid
        #1 txn_byte_vld = 1'b0;
        txn_data = ~txn_data;
        txn_done = 1'b1;
        txn_cksum_err = rsp_err[1];
        @(posedge clk);
        #1 txn_done = 1'b0;
        txn_nack = 1'b0;
        txn_cksum_err = 1'b0;
        txn_timeout = 1'b0;
      end
    end
  end
endmodule : smpc_engine_model
`default_nettype wire

//--- dv/smpc_assertions.sv
// port checker for the poll sequencer, mirrors the config registers
// assumes config writes land only while the master is idle or disabled
`timescale 1ns/1ps
`default_nettype none
module smpc_assertions
  import smpc_pkg::*;
#(
  parameter int NUM_DEV = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic txn_start,
  input wire logic [2:0] txn_dev,
  input wire logic txn_cksum,
  input wire logic txn_block,
  input wire logic txn_restart,
  input wire logic txn_done,
  input wire logic txn_nack,
  input wire logic [7:0] remote_one_temp,
  input wire logic [7:0] remote_two_temp,
  input wire logic [8*NUM_DEV-1:0] temp_vals,
  input wire logic poll_alert
);
  logic [7:0] rs_q, ck_q, fl_q, fh_q, mc_q, mk_q;
  logic [15:0] fmt_all;
  logic [1:0] dfmt;
  assign fmt_all = {fh_q, fl_q};
  assign dfmt = fmt_all[{txn_dev, 1'b0} +: 2];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rs_q <= 8'hff;
      ck_q <= 8'h00;
      fl_q <= 8'h03;
      fh_q <= 8'h00;
      mc_q <= 8'h08;
      mk_q <= 8'h00;
    end else if (reg_wr_en) begin
      case (reg_addr)
        SMPC_A_RESTART: rs_q <= reg_wdata;
        SMPC_A_CKSUM_EN: ck_q <= reg_wdata;
        SMPC_A_FMT_LOW: fl_q <= reg_wdata;
        SMPC_A_FMT_HIGH: fh_q <= reg_wdata;
        SMPC_A_MASTER: mc_q <= reg_wdata;
        SMPC_A_NACK_MASK: mk_q <= reg_wdata;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // mask must hold over the flag update for the alert to follow it
  sequence s_nack_done;
    txn_done && txn_nack && !mk_q[txn_dev] ##1 $stable(mk_q);
  endsequence
  AST_CKSUM: assert property (txn_start |-> txn_cksum == ck_q[txn_dev])
    else $error("checksum request differs from enable");
  AST_BLOCK: assert property (txn_start |-> txn_block ==
    ((txn_dev <= 3'h3 && dfmt == 2'b11) || (txn_dev == 3'h0 && mc_q[7])))
    else $error("block read request wrong");
  AST_RESERVED: assert property (txn_start |->
    !(txn_dev == 3'h4 && fh_q[1:0] == 2'b11))
    else $error("reserved format device polled");
  AST_OFF: assert property (!mc_q[0] [*3] |-> !txn_start)
    else $error("poll while master disabled");
  AST_REM_ONE: assert property (mc_q[5] && !mc_q[7] |=>
    temp_vals[15:8] == $past(remote_one_temp) &&
    temp_vals[23:16] == $past(remote_one_temp))
    else $error("remote one not copied");
  AST_REM_TWO: assert property (mc_q[6] && !mc_q[7] |=>
    temp_vals[31:24] == $past(remote_two_temp) &&
    temp_vals[39:32] == $past(remote_two_temp))
    else $error("remote two not copied");
  AST_HUB: assert property (txn_start && mc_q[7] |->
    !(txn_dev inside {[3'h1:3'h4]}))
    else $error("module polled in hub mode");
  AST_ALERT: assert property (s_nack_done |=> poll_alert)
    else $error("alert missing after no-ack");
  AST_MASK: assert property ((mk_q == 8'hff) [*3] |-> !poll_alert)
    else $error("alert while all masked");
  AST_RESTART: assert property (txn_start |->
    txn_restart == rs_q[txn_dev])
    else $error("restart request differs from enable");
endmodule : smpc_assertions
bind smpc_top smpc_assertions #(.NUM_DEV(NUM_DEV)) i_smpc_assertions (
  .clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .txn_start(txn_start),
  .txn_dev(txn_dev), .txn_cksum(txn_cksum), .txn_block(txn_block),
  .txn_restart(txn_restart), .txn_done(txn_done), .txn_nack(txn_nack),
  .remote_one_temp(remote_one_temp), .remote_two_temp(remote_two_temp),
  .temp_vals(temp_vals), .poll_alert(poll_alert)
);
`default_nettype wire

//--- dv/tb_smpc_top.sv
// testbench for the poll configuration and status block
// assumes the engine model on the transaction side, one 250 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_smpc_top;
  import smpc_pkg::*;
  logic clk, rst_n, reg_wr_en, reg_rd_en, slow;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, high_limit, low_limit;
  logic [7:0] remote_one_temp, remote_two_temp, mc;
  logic txn_start, txn_cksum, txn_block, txn_restart, txn_byte_vld;
  logic txn_done, txn_nack, txn_cksum_err, txn_timeout, poll_alert;
  logic [2:0] txn_dev, txn_byte_idx, rsp_err;
  logic [15:0] txn_data, rsp_data;
  logic [63:0] temp_vals;
  int fails, n_checks;
  smpc_top i_smpc_top (.clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .txn_start(txn_start), .txn_dev(txn_dev),
    .txn_cksum(txn_cksum), .txn_block(txn_block),
    .txn_restart(txn_restart), .txn_byte_vld(txn_byte_vld),
    .txn_byte_idx(txn_byte_idx), .txn_data(txn_data),
    .txn_done(txn_done), .txn_nack(txn_nack),
    .txn_cksum_err(txn_cksum_err), .txn_timeout(txn_timeout),
    .high_limit(high_limit), .low_limit(low_limit),
    .remote_one_temp(remote_one_temp), .remote_two_temp(remote_two_temp),
    .temp_vals(temp_vals), .poll_alert(poll_alert));
  smpc_engine_model i_smpc_engine_model (.clk(clk), .rst_n(rst_n),
    .txn_start(txn_start), .txn_dev(txn_dev), .txn_block(txn_block),
    .rsp_data(rsp_data), .rsp_err(rsp_err), .slow(slow),
    .txn_byte_vld(txn_byte_vld), .txn_byte_idx(txn_byte_idx),
    .txn_data(txn_data), .txn_done(txn_done), .txn_nack(txn_nack),
    .txn_cksum_err(txn_cksum_err), .txn_timeout(txn_timeout));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr_en = 1'b0;
  endtask : wr
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd_en = 1'b0;
    chk8(reg_rdata, exp);
  endtask : chk_reg
  // disable first so no request is loaded under a half-changed mode
  task automatic mode(input logic [7:0] v);
    wr(SMPC_A_MASTER, mc & 8'hfe);
    wr(SMPC_A_MASTER, v);
    mc = v;
  endtask : mode
  task automatic polls(input int n);
    int k;
    k = 0;
    repeat (4000) begin
      @(posedge clk);
      if (txn_done === 1'b1) k++;
      if (k >= n) break;
    end
    #1;
    chk8(8'(k), 8'(n));
  endtask : polls
  task automatic t_reset;
    chk_reg(SMPC_A_FMT_LOW, 8'h03);
    chk_reg(SMPC_A_MASTER, 8'h08);
    chk_reg(SMPC_A_RESTART, 8'hff);
    chk_reg(SMPC_A_CKSUM_EN, 8'h00);
    for (int a = 'hb6; a <= 'hbc; a++) chk_reg(8'(a), 8'h00);
    for (int i = 0; i < 8; i++) chk8(temp_vals[8*i +: 8], 8'h80);
  endtask : t_reset
  task automatic t_regs;
    wr(SMPC_A_CKSUM_EN, 8'ha5);
    chk_reg(SMPC_A_CKSUM_EN, 8'ha5);
    wr(SMPC_A_FMT_HIGH, 8'h5a);
    chk_reg(SMPC_A_FMT_HIGH, 8'h5a);
    wr(SMPC_A_RESTART, 8'h5a);
    chk_reg(SMPC_A_RESTART, 8'h5a);
    for (int a = 'hb6; a <= 'hba; a++) begin
      wr(8'(a), 8'hff);
      chk_reg(8'(a), 8'h00);
    end
    wr(8'hb4, 8'hff);
    chk_reg(8'hb4, 8'h00);
  endtask : t_regs
  task automatic t_off;
    int n;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (txn_start === 1'b1) n++;
    end
    chk8(8'(n), 8'h00);
  endtask : t_off
  task automatic t_fmt;
    wr(SMPC_A_CKSUM_EN, 8'h05);
    wr(SMPC_A_FMT_HIGH, 8'hb7);
    rsp_data = 16'h0190;
    slow = 1'b1;
    mode(8'h09);
    polls(16);
    slow = 1'b0;
    chk8(temp_vals[7:0], 8'h90);
    chk8(temp_vals[15:8], 8'h90);
    chk8(temp_vals[39:32], 8'h80);
    chk8(temp_vals[47:40], 8'h19);
    chk8(temp_vals[55:48], 8'h90);
    chk_reg(SMPC_A_CKSUM_ERR, 8'h00);
    chk_reg(SMPC_A_LIMIT, 8'hc0);
  endtask : t_fmt
  task automatic t_err;
    rsp_err = 3'b111;
    polls(16);
    chk_reg(SMPC_A_NO_ACK, 8'hef);
    chk_reg(SMPC_A_TIMEOUT, 8'hef);
    chk_reg(SMPC_A_CKSUM_ERR, 8'h05);
    chk8({7'h0, poll_alert}, 8'h01);
    wr(SMPC_A_NACK_MASK, 8'hff);
    chk_reg(SMPC_A_NO_ACK, 8'hef);
    chk8({7'h0, poll_alert}, 8'h00);
    wr(SMPC_A_NACK_MASK, 8'h00);
    rsp_err = 3'b000;
    polls(16);
    chk_reg(SMPC_A_NO_ACK, 8'h00);
  endtask : t_err
  task automatic t_lim;
    mode(8'h08);
    wr(SMPC_A_FMT_HIGH, 8'h00);
    high_limit = 8'h40;
    low_limit = 8'h00;
    rsp_data = 16'h0050;
    mode(8'h09);
    polls(16);
    chk_reg(SMPC_A_LIMIT, 8'hff);
    rsp_data = 16'h003e;
    polls(16);
    chk_reg(SMPC_A_LIMIT, 8'hff);
    mode(8'h01);
    polls(16);
    chk_reg(SMPC_A_LIMIT, 8'h00);
  endtask : t_lim
  task automatic t_sub;
    mode(8'h29);
    polls(8);
    chk8(temp_vals[15:8], 8'h55);
    chk8(temp_vals[23:16], 8'h55);
    mode(8'h49);
    polls(8);
    chk8(temp_vals[31:24], 8'h66);
    chk8(temp_vals[39:32], 8'h66);
    rsp_data = 16'h00ff;
    mode(8'he9);
    polls(16);
    chk8(temp_vals[15:8], 8'h00);
    chk8(temp_vals[39:32], 8'h03);
    chk_reg(SMPC_A_INVALID, 8'h01);
  endtask : t_sub
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst_n, reg_wr_en, reg_rd_en, slow} = 4'h0;
    {reg_addr, reg_wdata, mc} = {8'h00, 8'h00, 8'h08};
    {high_limit, low_limit} = {8'h7f, 8'h81};
    {remote_one_temp, remote_two_temp} = {8'h55, 8'h66};
    rsp_data = 16'h0000;
    rsp_err = 3'b000;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset;
    t_regs;
    t_off;
    t_fmt;
    t_err;
    t_lim;
    t_sub;
    summarize;
  end
  // all scenarios need under a thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    summarize;
  end
endmodule : tb_smpc_top
`default_nettype wire
